// ===== design/dpgpio_pkg.sv
// Package with register map, field layouts and reset values for the GPIO block.
package dpgpio_pkg;
  localparam int          PA_PINS          = 5;
  localparam int          PB_PINS          = 8;
  localparam logic [11:0] OFS_PA_DATA      = 12'h000;
  localparam logic [11:0] OFS_PB_DATA      = 12'h004;
  localparam logic [11:0] OFS_PA_DIR       = 12'h008;
  localparam logic [11:0] OFS_PB_DIR       = 12'h00c;
  localparam logic [11:0] OFS_PA_PULLUP    = 12'h010;
  localparam logic [11:0] OFS_PB_SHARE     = 12'h014;
  localparam int          SH_SERIAL_EN     = 0;
  localparam int          SH_CLKOUT_SEL    = 1;
  localparam int          SH_CLKOUT_EN     = 2;
  localparam int          SH_CLKIN_SEL     = 3;
  localparam int          SH_CLKIN_EN      = 4;
  localparam int          SH_ANALOG_LSB    = 8;
  localparam int          SH_WIDTH         = 5;
  localparam int          ANALOG_PINS      = 4;
  localparam int          PB_RX_PIN        = 1;
  localparam int          PB_TX_PIN        = 0;
  localparam int          PB_CLKIN_PIN     = 6;
  localparam int          PB_CLKOUT_PIN    = 7;
  localparam logic [4:0]  PA_DIR_RESET     = 5'h00;
  localparam logic [4:0]  PA_PULLUP_RESET  = 5'h00;
  localparam logic [7:0]  PB_DIR_RESET     = 8'h00;
  localparam logic [4:0]  SHARE_RESET      = 5'h00;
  localparam logic [3:0]  ANALOG_RESET     = 4'h0;
  localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;
  localparam logic [2:0]  HSIZE_WORD       = 3'h2;
endpackage

// ===== design/dpgpio_pin_mux.sv
// Per-pin output enable, output value and pull-up selection for one port.
`timescale 1ns/1ns
module dpgpio_pin_mux #(
  parameter int WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] latch,
  input  wire logic [WIDTH-1:0] dir,
  input  wire logic [WIDTH-1:0] pullup_req,
  input  wire logic [WIDTH-1:0] sampled,
  input  wire logic [WIDTH-1:0] periph_own,
  input  wire logic [WIDTH-1:0] periph_drive,
  input  wire logic [WIDTH-1:0] periph_out,
  output logic      [WIDTH-1:0] pad_out,
  output logic      [WIDTH-1:0] pad_oe_n,
  output logic      [WIDTH-1:0] pad_pullup,
  output logic      [WIDTH-1:0] read_value
);
  initial begin
    if (WIDTH < 1) begin
      $error("dpgpio_pin_mux needs at least one pin.");
    end
  end

  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      if (periph_own[i]) begin
        pad_oe_n[i] = ~periph_drive[i];
        pad_out[i]  = periph_out[i];
      end else begin
        pad_oe_n[i] = ~dir[i];
        pad_out[i]  = latch[i];
      end
      pad_pullup[i] = pullup_req[i] & pad_oe_n[i] & ~periph_own[i];
      read_value[i] = dir[i] ? latch[i] : sampled[i];
    end
  end
endmodule

// ===== design/dpgpio_top.sv
// Top of the dual-port GPIO block with its AHB-Lite register slave.
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
module dpgpio_top #(
  parameter int PA_WIDTH = dpgpio_pkg::PA_PINS,
  parameter int PB_WIDTH = dpgpio_pkg::PB_PINS
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic [PA_WIDTH-1:0] port_a_in,
  output logic      [PA_WIDTH-1:0] port_a_out,
  output logic      [PA_WIDTH-1:0] port_a_oe_n,
  output logic      [PA_WIDTH-1:0] port_a_pullup,
  input  wire logic [PB_WIDTH-1:0] port_b_in,
  output logic      [PB_WIDTH-1:0] port_b_out,
  output logic      [PB_WIDTH-1:0] port_b_oe_n,
  input  wire logic                serial_tx_data,
  input  wire logic                serial_tx_enable,
  output logic                     serial_rx_data,
  input  wire logic                clock_gen_enable,
  input  wire logic                clock_gen_out,
  output logic                     external_clock_input,
  output logic [dpgpio_pkg::ANALOG_PINS-1:0] analog_in,
  output logic                     serial_interface_enable,
  output logic                     clock_output_pin_active,
  output logic                     external_clock_input_active
);
  initial begin
    if (PA_WIDTH != dpgpio_pkg::PA_PINS || PB_WIDTH != dpgpio_pkg::PB_PINS) begin
      $error("dpgpio_top supports only the documented port widths.");
    end
  end

  localparam int AN = dpgpio_pkg::ANALOG_PINS;

  logic [PA_WIDTH-1:0] port_a_pin_latch_reg;
  logic [PA_WIDTH-1:0] port_a_direction_reg;
  logic [PA_WIDTH-1:0] port_a_pullup_enable_reg;
  logic [PB_WIDTH-1:0] port_b_pin_latch_reg;
  logic [PB_WIDTH-1:0] port_b_direction_reg;
  logic [dpgpio_pkg::SH_WIDTH-1:0] share_reg;
  logic [AN-1:0]       analog_sel_reg;
  logic                wr_pend_reg;
  logic [11:0]         wr_addr_reg;
  logic [31:0]         rdata_reg;
  logic [PA_WIDTH-1:0] pa_read;
  logic [PB_WIDTH-1:0] pb_read;
  logic [PB_WIDTH-1:0] pb_own;
  logic [PB_WIDTH-1:0] pb_drive;
  logic [PB_WIDTH-1:0] pb_pout;
  logic                addr_phase;

  // Decodes the word offset used for both reads and writes.
  function automatic logic [11:0] word_ofs(input logic [31:0] a);
    word_ofs = {a[11:2], 2'b00};
  endfunction

  // Places a narrow field in the low bits so the upper bits read as zero.
  function automatic logic [31:0] zext8(input logic [7:0] v);
    zext8 = {24'h000000, v};
  endfunction

  assign addr_phase = hsel & hready & (htrans == dpgpio_pkg::HTRANS_NONSEQ);
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = rdata_reg;

  assign serial_interface_enable = share_reg[dpgpio_pkg::SH_SERIAL_EN];
  assign clock_output_pin_active = share_reg[dpgpio_pkg::SH_CLKOUT_SEL] &
                                   share_reg[dpgpio_pkg::SH_CLKOUT_EN] &
                                   clock_gen_enable;
  assign external_clock_input_active = share_reg[dpgpio_pkg::SH_CLKIN_SEL] &
                                       share_reg[dpgpio_pkg::SH_CLKIN_EN] &
                                       clock_gen_enable;

  // Write address is captured in the address phase and used in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 12'h000;
    end else if (hready) begin
      wr_pend_reg <= addr_phase & hwrite;
      wr_addr_reg <= word_ofs(haddr);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_a_direction_reg <= dpgpio_pkg::PA_DIR_RESET;
    end else if (wr_pend_reg && wr_addr_reg == dpgpio_pkg::OFS_PA_DIR) begin
      port_a_direction_reg <= hwdata[PA_WIDTH-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_a_pullup_enable_reg <= dpgpio_pkg::PA_PULLUP_RESET;
    end else if (wr_pend_reg && wr_addr_reg == dpgpio_pkg::OFS_PA_PULLUP) begin
      port_a_pullup_enable_reg <= hwdata[PA_WIDTH-1:0];
    end
  end

  // Port A latch keeps its value over reset too; no reset value is defined.
  always_ff @(posedge hclk) begin
    if (wr_pend_reg && wr_addr_reg == dpgpio_pkg::OFS_PA_DATA) begin
      port_a_pin_latch_reg <= hwdata[PA_WIDTH-1:0];
    end
  end

  // Deliberately unreset so that port B data survives a system reset.
  always_ff @(posedge hclk) begin
    if (wr_pend_reg && wr_addr_reg == dpgpio_pkg::OFS_PB_DATA) begin
      port_b_pin_latch_reg <= hwdata[PB_WIDTH-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_b_direction_reg <= dpgpio_pkg::PB_DIR_RESET;
    end else if (wr_pend_reg && wr_addr_reg == dpgpio_pkg::OFS_PB_DIR) begin
      port_b_direction_reg <= hwdata[PB_WIDTH-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      share_reg      <= dpgpio_pkg::SHARE_RESET;
      analog_sel_reg <= dpgpio_pkg::ANALOG_RESET;
    end else if (wr_pend_reg && wr_addr_reg == dpgpio_pkg::OFS_PB_SHARE) begin
      share_reg      <= hwdata[dpgpio_pkg::SH_WIDTH-1:0];
      analog_sel_reg <= hwdata[dpgpio_pkg::SH_ANALOG_LSB +: AN];
    end
  end

  // Read data is registered in the address phase, so it stands in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= 32'h00000000;
    end else if (addr_phase && !hwrite) begin
      unique case (word_ofs(haddr))
        dpgpio_pkg::OFS_PA_DATA:   rdata_reg <= zext8({3'h0, pa_read});
        dpgpio_pkg::OFS_PB_DATA:   rdata_reg <= zext8(pb_read);
        dpgpio_pkg::OFS_PA_DIR:    rdata_reg <= zext8({3'h0, port_a_direction_reg});
        dpgpio_pkg::OFS_PB_DIR:    rdata_reg <= zext8(port_b_direction_reg);
        dpgpio_pkg::OFS_PA_PULLUP: rdata_reg <= zext8({3'h0, port_a_pullup_enable_reg});
        dpgpio_pkg::OFS_PB_SHARE:  rdata_reg <= {20'h00000, analog_sel_reg,
                                                 3'h0, share_reg};
        default:                   rdata_reg <= 32'h00000000;
      endcase
    end
  end

  // Peripheral ownership of the shared port B pins.
  always_comb begin
    pb_own   = '0;
    pb_drive = '0;
    pb_pout  = '0;
    pb_own[dpgpio_pkg::PB_RX_PIN]     = serial_interface_enable;
    pb_own[dpgpio_pkg::PB_TX_PIN]     = serial_interface_enable;
    pb_drive[dpgpio_pkg::PB_TX_PIN]   = serial_tx_enable;
    pb_pout[dpgpio_pkg::PB_TX_PIN]    = serial_tx_data;
    pb_own[dpgpio_pkg::PB_CLKIN_PIN]  = external_clock_input_active;
    pb_own[dpgpio_pkg::PB_CLKOUT_PIN] = clock_output_pin_active;
    pb_drive[dpgpio_pkg::PB_CLKOUT_PIN] = clock_output_pin_active;
    pb_pout[dpgpio_pkg::PB_CLKOUT_PIN]  = clock_gen_out;
    // Analog pins are owned as inputs so digital output drive is cut off.
    pb_own[AN+1:2] = analog_sel_reg;
  end

  // Receive and clock input follow the pin only while the peripheral owns it.
  assign serial_rx_data = serial_interface_enable ?
                          port_b_in[dpgpio_pkg::PB_RX_PIN] : 1'b1;
  assign external_clock_input = external_clock_input_active &
                                port_b_in[dpgpio_pkg::PB_CLKIN_PIN];
  assign analog_in = port_b_in[AN+1:2] & analog_sel_reg;

  dpgpio_pin_mux #(
    .WIDTH (PA_WIDTH)
  ) u_port_a (
    .latch        (port_a_pin_latch_reg),
    .dir          (port_a_direction_reg),
    .pullup_req   (port_a_pullup_enable_reg),
    .sampled      (port_a_in),
    .periph_own   ({PA_WIDTH{1'b0}}),
    .periph_drive ({PA_WIDTH{1'b0}}),
    .periph_out   ({PA_WIDTH{1'b0}}),
    .pad_out      (port_a_out),
    .pad_oe_n     (port_a_oe_n),
    .pad_pullup   (port_a_pullup),
    .read_value   (pa_read)
  );

  dpgpio_pin_mux #(
    .WIDTH (PB_WIDTH)
  ) u_port_b (
    .latch        (port_b_pin_latch_reg),
    .dir          (port_b_direction_reg),
    .pullup_req   ({PB_WIDTH{1'b0}}),
    .sampled      (port_b_in),
    .periph_own   (pb_own),
    .periph_drive (pb_drive),
    .periph_out   (pb_pout),
    .pad_out      (port_b_out),
    .pad_oe_n     (port_b_oe_n),
    .pad_pullup   (),
    .read_value   (pb_read)
  );
endmodule

// ===== dv/dpgpio_top_sva.sv
// Checker that ties the GPIO block's pins and read data to bus traffic.
`timescale 1ns/1ns
module dpgpio_top_sva (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic [31:0] hrdata,
  input wire logic [4:0]  port_a_in,
  input wire logic [4:0]  port_a_out,
  input wire logic [4:0]  port_a_oe_n,
  input wire logic [4:0]  port_a_pullup,
  input wire logic [7:0]  port_b_in,
  input wire logic [7:0]  port_b_oe_n,
  input wire logic        serial_rx_data,
  input wire logic        serial_interface_enable,
  input wire logic        external_clock_input,
  input wire logic        external_clock_input_active
);
  logic        ph_wr;
  logic        ph_rd;
  logic [11:0] ph_adr;
  wire         take = hsel && hready && htrans == dpgpio_pkg::HTRANS_NONSEQ;
  // Data phase flags let each effect be tied to the word that caused it.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr  <= 1'b0;
      ph_rd  <= 1'b0;
      ph_adr <= 12'h000;
    end else begin
      ph_wr  <= take && hwrite;
      ph_rd  <= take && !hwrite;
      ph_adr <= haddr[11:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_wr(logic [11:0] a);
    ph_wr && ph_adr == a;
  endsequence
  a_dir_drives: assert property (s_wr(dpgpio_pkg::OFS_PA_DIR) |=>
    port_a_oe_n == ~$past(hwdata[4:0])) else $error("bad port A enable");
  a_pullup_sel: assert property (s_wr(dpgpio_pkg::OFS_PA_PULLUP) |=>
    port_a_pullup == ($past(hwdata[4:0]) & port_a_oe_n))
    else $error("bad port A pull-up");
  a_latch_out: assert property (s_wr(dpgpio_pkg::OFS_PA_DATA) |=>
    port_a_out == $past(hwdata[4:0])) else $error("bad port A latch");
  a_pullup_off: assert property ((port_a_pullup & ~port_a_oe_n) == 5'h00)
    else $error("pull-up on a driven pin");
  a_reset_input: assert property ($rose(hresetn) |->
    &port_a_oe_n && &port_b_oe_n) else $error("pin driven after reset");
  a_read_mix: assert property (ph_rd && ph_adr == dpgpio_pkg::OFS_PA_DATA |->
    hrdata == {27'h0, ($past(port_a_out) & ~$past(port_a_oe_n)) |
    ($past(port_a_in) & $past(port_a_oe_n))}) else $error("bad port A read");
  a_rx_route: assert property (serial_rx_data ==
    (serial_interface_enable ? port_b_in[1] : 1'b1)) else $error("bad rx");
  a_clkin_route: assert property (external_clock_input ==
    (external_clock_input_active & port_b_in[6])) else $error("bad clock in");
endmodule
bind dpgpio_top dpgpio_top_sva i_sva (.hclk, .hresetn, .hsel, .haddr,
  .htrans, .hwrite, .hready, .hwdata, .hrdata, .port_a_in, .port_a_out,
  .port_a_oe_n, .port_a_pullup, .port_b_in, .port_b_oe_n, .serial_rx_data,
  .serial_interface_enable, .external_clock_input,
  .external_clock_input_active);

// ===== dv/dpgpio_pins.sv
// Board model of the port pins: drivers, pull-ups and floating inputs.
`timescale 1ns/1ns
module dpgpio_pins (
  input  wire logic       hclk,
  input  wire logic [4:0] ext_a,
  input  wire logic [4:0] ext_a_en,
  input  wire logic [7:0] ext_b,
  input  wire logic [4:0] a_out,
  input  wire logic [4:0] a_oe_n,
  input  wire logic [4:0] a_pullup,
  input  wire logic [7:0] b_out,
  input  wire logic [7:0] b_oe_n,
  output logic      [4:0] a_pin,
  output logic      [7:0] b_pin
);
  logic [4:0] float_q = 5'h0a;
  // A floating pin wanders every cycle, so no test can lean on it.
  always @(posedge hclk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (!a_oe_n[i]) a_pin[i] = a_out[i];
      else if (ext_a_en[i]) a_pin[i] = ext_a[i];
      else if (a_pullup[i]) a_pin[i] = 1'b1;
      else a_pin[i] = float_q[i];
    end
  end
  assign b_pin = (b_out & ~b_oe_n) | (ext_b & b_oe_n);
endmodule

// ===== dv/dpgpio_top_bench.sv
// Register-level tests of the GPIO block over its bus and pins.
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %0t got %h want %h", $time, a, e); end end
module dpgpio_top_bench;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = dpgpio_pkg::HSIZE_WORD;
  logic hreadyout, hresp, serial_rx_data, external_clock_input;
  logic serial_interface_enable, clock_output_pin_active;
  logic external_clock_input_active, clock_gen_enable = 1'b0;
  logic tx_en = 1'b0, tx_d = 1'b0;
  logic [4:0] port_a_in, port_a_out, port_a_oe_n, port_a_pullup;
  logic [4:0] ext_a = 5'h0a, ext_a_en = 5'h1f;
  logic [7:0] port_b_in, port_b_out, port_b_oe_n, ext_b = 8'h3c;
  logic [3:0] analog_in;
  wire hready = hreadyout;
  int error_cnt = 0, cmp_count = 0;
  dpgpio_top i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .port_a_in, .port_a_out,
    .port_a_oe_n, .port_a_pullup, .port_b_in, .port_b_out, .port_b_oe_n,
    .serial_tx_data(tx_d), .serial_tx_enable(tx_en), .serial_rx_data,
    .clock_gen_enable, .clock_gen_out(1'b0), .external_clock_input,
    .analog_in, .serial_interface_enable, .clock_output_pin_active,
    .external_clock_input_active);
  dpgpio_pins i_pins (.hclk, .ext_a, .ext_a_en, .ext_b, .a_out(port_a_out),
    .a_oe_n(port_a_oe_n), .a_pullup(port_a_pullup), .b_out(port_b_out),
    .b_oe_n(port_b_oe_n), .a_pin(port_a_in), .b_pin(port_b_in));
  initial begin
    forever #20 hclk = ~hclk;
  end
  task automatic ahb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= dpgpio_pkg::HTRANS_NONSEQ;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] v;
    ahb(1'b1, a, d, v);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] v;
    ahb(1'b0, a, 32'h0, v);
    `CHK(v, e)
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    error_cnt++;
    final_report;
  end
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(dpgpio_pkg::OFS_PA_DIR, 32'h0);
    rd_chk(dpgpio_pkg::OFS_PA_PULLUP, 32'h0);
    wr(dpgpio_pkg::OFS_PA_DIR, 32'hffffffff);
    rd_chk(dpgpio_pkg::OFS_PA_DIR, 32'h1f);
    wr(dpgpio_pkg::OFS_PA_DIR, 32'h0);
    wr(dpgpio_pkg::OFS_PA_DATA, 32'h15);
    rd_chk(dpgpio_pkg::OFS_PA_DATA, 32'h0a);
    wr(dpgpio_pkg::OFS_PA_DIR, 32'h03);
    rd_chk(dpgpio_pkg::OFS_PA_DATA, 32'h09);
    wr(dpgpio_pkg::OFS_PA_DIR, 32'h1f);
    rd_chk(dpgpio_pkg::OFS_PA_DATA, 32'h15);
    `CHK(port_a_oe_n, 5'h00)
    wr(dpgpio_pkg::OFS_PA_DIR, 32'h0);
    ext_a_en <= 5'h00;
    wr(dpgpio_pkg::OFS_PA_PULLUP, 32'h1f);
    rd_chk(dpgpio_pkg::OFS_PA_DATA, 32'h1f);
    wr(dpgpio_pkg::OFS_PA_DIR, 32'h04);
    wr(dpgpio_pkg::OFS_PA_PULLUP, 32'h05);
    #1 `CHK(port_a_pullup, 5'h01)
    wr(dpgpio_pkg::OFS_PB_DATA, 32'ha5);
    wr(dpgpio_pkg::OFS_PB_DIR, 32'hff);
    rd_chk(dpgpio_pkg::OFS_PB_DATA, 32'ha5);
    wr(dpgpio_pkg::OFS_PB_DIR, 32'h0f);
    rd_chk(dpgpio_pkg::OFS_PB_DATA, 32'h35);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    #1 `CHK(port_b_out, 8'ha5)
    rd_chk(dpgpio_pkg::OFS_PB_DIR, 32'h0);
    wr(dpgpio_pkg::OFS_PB_SHARE, 32'h0f01);
    #1 `CHK(serial_rx_data, 1'b0)
    `CHK(analog_in, 4'hf)
    @(posedge hclk);
    tx_en <= 1'b1;
    tx_d  <= 1'b1;
    #1 `CHK(port_b_oe_n[0], 1'b0)
    `CHK(port_b_out[0], 1'b1)
    wr(dpgpio_pkg::OFS_PB_SHARE, 32'h0);
    #1 `CHK(port_b_oe_n[0], 1'b1)
    ext_b <= 8'h40;
    clock_gen_enable <= 1'b1;
    #1 `CHK(serial_rx_data, 1'b1)
    wr(dpgpio_pkg::OFS_PB_SHARE, 32'h18);
    #1 `CHK(external_clock_input, 1'b1)
    @(posedge hclk) clock_gen_enable <= 1'b0;
    repeat (2) @(posedge hclk);
    #1 `CHK(external_clock_input_active, 1'b0)
    @(posedge hclk);
    clock_gen_enable <= 1'b1;
    wr(dpgpio_pkg::OFS_PB_SHARE, 32'h06);
    #1 `CHK(clock_output_pin_active, 1'b1)
    `CHK(port_b_oe_n[7], 1'b0)
    `CHK(port_b_oe_n[6], 1'b1)
    `CHK(hresp, 1'b0)
    rd_chk(12'h020, 32'h0);
    final_report;
  end
endmodule
